// File: src/dma_controller.sv
// multichannel dma engine: arbitration, descriptor walk, data moves
//
// Notes on behaviour
// - item size of 8, 16 or 32 bits comes from each descriptor
// - source and destination step byte, half, word or not at all
// - two priority levels; pending high channels are served first
// - items per burst before re-arbitration set per descriptor
// - bus accesses only issued while the processor leaves the bus idle
// - each peripheral path owns its own channel and request line
// - the top channel has no peripheral request, software only
// - every channel also accepts a software request
// - enable and configuration are held per channel
// - a completion pulse is raised for the finished channel
// - basic mode moves only while request stands, pauses otherwise
// - auto mode runs to the end once started by one request
// - ping-pong flips between primary and alternate and keeps going
// - memory scatter-gather copies tasks to alternate and runs each
// - peripheral scatter-gather advances tasks only on requests
// - completion clears the channel enable
// - alternate entries sit at table indices 32 to 63
// - remaining count decrements per item, reads zero when done
`timescale 1ns/1ps
module dma_controller
    import dma_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // configuration
    input  wire logic              ctrl_enable,
    input  wire logic [31:10]      table_base,
    input  wire logic [NUM_CH-1:0] prio_high,
    // channel control
    input  wire logic [NUM_CH-1:0] chan_enable_set,
    input  wire logic [NUM_CH-1:0] chan_disable,
    input  wire logic [NUM_CH-1:0] sw_req,
    input  wire logic [NUM_CH-2:0] periph_req,
    input  wire logic              err_clear,
    // status
    output logic      [NUM_CH-1:0] chan_enabled,
    output logic      [NUM_CH-1:0] chan_done,
    output logic                   error_irq,
    // memory bus master
    input  wire logic              cpu_bus_busy,
    output logic                   bus_valid,
    output logic                   bus_write,
    output logic      [31:0]       bus_addr,
    output logic      [31:0]       bus_wdata,
    output logic      [1:0]        bus_size,
    input  wire logic              bus_ready,
    input  wire logic [31:0]       bus_rdata,
    input  wire logic              bus_err
);

    // ****************************************************************
    // state
    // ****************************************************************
    state_e            state_q, state_d;
    logic [CH_W-1:0]   ch_q;
    logic [1:0]        w_q;
    logic [15:0]       beat_q;
    logic [31:0]       src_q, dst_q, ctl_q, data_q;
    logic [NUM_CH-1:0] en_q, run_q, alt_q, sg_q, per_q, last_q, done_q;
    logic [NUM_CH-2:0] req_s1_q, req_s2_q;
    logic              err_q;

    // ****************************************************************
    // request gathering
    // ****************************************************************
    // pins pass two flops; the top channel has no pin at all
    wire [NUM_CH-1:0] req_all = {1'b0, req_s2_q} | sw_req;
    wire [NUM_CH-1:0] pend    = en_q & (req_all | run_q);
    wire [CH_W-1:0]   gnt;
    wire              any;

    dma_arbiter u_arb (
        .pend (pend),
        .high (prio_high),
        .gnt  (gnt),
        .any  (any)
    );

    // ****************************************************************
    // descriptor decode
    // ****************************************************************
    wire [2:0]       mode_w = ctl_q[CTL_MODE_LSB +: 3];
    wire [CNT_W-1:0] cnt_w  = ctl_q[CTL_CNT_LSB +: CNT_W];
    wire [3:0]       arb_w  = ctl_q[CTL_ARB_LSB +: 4];
    wire [1:0]       size_w = ctl_q[CTL_SIZE_LSB +: 2];
    wire [CNT_W-1:0] cnt_dec = cnt_w - CNT_W'(1);
    wire             cnt_z  = (cnt_w == '0);
    wire             alt_c  = alt_q[ch_q];
    // primary of a task list copies one task word per item
    wire sg_prim = !alt_c && (mode_w == MODE_MEM_SG ||
                              mode_w == MODE_PER_SG);
    // modes that move only while the request stands
    wire level_w = mode_w == MODE_BASIC || mode_w == MODE_PER_SG ||
                   (alt_c && sg_q[ch_q] && per_q[ch_q]);
    wire [31:0] src_step = sg_prim ? inc_step(INC_WORD)
                         : inc_step(ctl_q[CTL_SINC_LSB +: 2]);
    wire [31:0] dst_step = sg_prim ? inc_step(INC_WORD)
                         : inc_step(ctl_q[CTL_DINC_LSB +: 2]);
    wire [15:0] beat_nx = beat_q + 16'h0001;
    wire [15:0] arb_lim = 16'h0001 << arb_w;

    // burst ends on count, arbitration size, dropped request or task edge
    wire stop_w = cnt_dec == '0 || beat_nx == arb_lim ||
                  (level_w && !req_all[ch_q]) ||
                  (sg_prim && cnt_dec[1:0] == 2'h0);

    // ****************************************************************
    // bus access
    // ****************************************************************
    wire active = state_q != S_IDLE;
    wire acc    = bus_valid && bus_ready;
    wire ok     = acc && !bus_err;
    wire errhit = acc && bus_err;
    wire [1:0]  tw = 2'h0 - cnt_w[1:0];
    // alternate entries live in the upper half of the table
    wire [31:0] desc_addr = {table_base, alt_c, 5'(ch_q), w_q, 2'b00};
    wire [31:0] task_addr = {table_base, 1'b1, 5'(ch_q), tw, 2'b00};
    wire [31:0] wb_word = w_q == W_SRC ? src_q
                        : w_q == W_DST ? dst_q : ctl_q;

    // processor traffic always wins the bus
    assign bus_valid = active && !cpu_bus_busy;
    assign bus_write = state_q == S_WR || state_q == S_WB;
    assign bus_addr  = state_q == S_RD ? src_q
                     : state_q == S_WR ? (sg_prim ? task_addr : dst_q)
                     : desc_addr;
    assign bus_wdata = state_q == S_WB ? wb_word : data_q;
    assign bus_size  = (state_q == S_RD || state_q == S_WR) && !sg_prim
                     ? size_w : SIZE_WORD;

    // ****************************************************************
    // end of burst decisions
    // ****************************************************************
    wire fetch_end = state_q == S_FETCH && ok && w_q == W_CTL;
    wire wb_end    = state_q == S_WB && ok && w_q == W_CTL;
    wire bad_desc  = bus_rdata[CTL_MODE_LSB +: 3] == MODE_STOP ||
                     bus_rdata[CTL_CNT_LSB +: CNT_W] == '0;
    wire pp_flip   = wb_end && cnt_z && mode_w == MODE_PP;
    wire sg_go     = wb_end && sg_prim && cnt_w[1:0] == 2'h0;
    wire sg_back   = wb_end && cnt_z && alt_c && sg_q[ch_q] &&
                     !last_q[ch_q];
    wire fin = (wb_end && cnt_z && mode_w != MODE_PP && !sg_prim &&
                !sg_back) || (fetch_end && bad_desc) || errhit;
    wire done_now = (fin && !errhit) || pp_flip;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE:  if (ctrl_enable && any) state_d = S_FETCH;
            S_FETCH: begin
                if (errhit || (fetch_end && bad_desc)) state_d = S_IDLE;
                else if (fetch_end) state_d = S_RD;
            end
            S_RD: begin
                if (errhit) state_d = S_IDLE;
                else if (ok) state_d = S_WR;
            end
            S_WR: begin
                if (errhit) state_d = S_IDLE;
                else if (ok) state_d = stop_w ? S_WB : S_RD;
            end
            S_WB: if (errhit || wb_end) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // datapath: descriptor words, moved item, pointers and count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            ch_q    <= '0;
            w_q     <= '0;
            beat_q  <= '0;
            src_q   <= '0;
            dst_q   <= '0;
            ctl_q   <= '0;
            data_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == S_IDLE) begin
                ch_q   <= gnt;
                w_q    <= W_SRC;
                beat_q <= '0;
            end
            if ((state_q == S_FETCH || state_q == S_WB) && ok)
                w_q <= (w_q == W_CTL) ? W_SRC : w_q + 2'h1;
            if (state_q == S_FETCH && ok) begin
                if (w_q == W_SRC) src_q <= bus_rdata;
                if (w_q == W_DST) dst_q <= bus_rdata;
                if (w_q == W_CTL) ctl_q <= bus_rdata;
            end
            if (state_q == S_RD && ok) data_q <= bus_rdata;
            if (state_q == S_WR && ok) begin
                src_q  <= src_q + src_step;
                dst_q  <= dst_q + dst_step;
                beat_q <= beat_nx;
                ctl_q[CTL_CNT_LSB +: CNT_W] <= cnt_dec;
            end
        end
    end

    // per channel enable, run latch, descriptor select and task state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q   <= '0;
            run_q  <= '0;
            alt_q  <= '0;
            sg_q   <= '0;
            per_q  <= '0;
            last_q <= '0;
            done_q <= '0;
            err_q  <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                logic sel;
                sel = active && ch_q == CH_W'(i);
                // software set wins over a completion in the same cycle
                en_q[i] <= chan_enable_set[i] || (en_q[i] &&
                           !chan_disable[i] && !(sel && fin));
                run_q[i] <= en_q[i] && !(sel && fin) &&
                            (req_all[i] || (run_q[i] &&
                            !(sel && wb_end && level_w)));
                done_q[i] <= sel && done_now;
                if (sel && fin) alt_q[i] <= 1'b0;
                else if (sel && pp_flip) alt_q[i] <= !alt_q[i];
                else if (sel && sg_go) alt_q[i] <= 1'b1;
                else if (sel && sg_back) alt_q[i] <= 1'b0;
                if (sel && fetch_end && !alt_q[i]) begin
                    sg_q[i]  <= bus_rdata[2:0] == MODE_MEM_SG ||
                                bus_rdata[2:0] == MODE_PER_SG;
                    per_q[i] <= bus_rdata[2:0] == MODE_PER_SG;
                end
                if (sel && sg_go) last_q[i] <= cnt_z;
            end
            err_q <= errhit || (err_q && !err_clear);
        end
    end

    // peripheral request pins cross in through two flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_s1_q <= '0;
            req_s2_q <= '0;
        end else begin
            req_s1_q <= periph_req;
            req_s2_q <= req_s1_q;
        end
    end

    assign chan_enabled = en_q;
    assign chan_done    = done_q;
    assign error_irq    = err_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    wire [NUM_CH-1:0] lower = (NUM_CH'(1) << gnt) - NUM_CH'(1);
    wire [NUM_CH-1:0] level = prio_high[gnt] ? prio_high : ~prio_high;

    chk_cpu_yield: assert property (cpu_bus_busy |-> !bus_valid)
        else $error("bus access issued while processor busy");
    chk_prio_level: assert property (state_q == S_IDLE && ctrl_enable && any
        |-> prio_high[gnt] || !(|(pend & prio_high)))
        else $error("default channel beat a high channel");
    chk_low_first: assert property (state_q == S_IDLE && ctrl_enable && any
        |-> (pend & lower & level) == '0)
        else $error("higher numbered channel won its level");
    chk_burst_limit: assert property ((state_q == S_RD || state_q == S_WR)
        |-> beat_q < arb_lim)
        else $error("burst ran past its arbitration size");
    chk_count_dec: assert property (state_q == S_WR && ok
        |=> cnt_w == $past(cnt_w) - CNT_W'(1))
        else $error("count did not drop by one");
    chk_src_step: assert property (state_q == S_WR && ok
        |=> src_q == $past(src_q) + $past(src_step))
        else $error("source pointer stepped wrongly");
    chk_basic_pause: assert property (state_q == S_WR && ok && level_w &&
        !req_all[ch_q] |=> state_q == S_WB
        ##[3:8] state_q == S_IDLE)
        else $error("level mode kept moving without request");
    chk_fin_disable: assert property (fin && !chan_enable_set[ch_q]
        |=> !en_q[$past(ch_q)] && run_q[$past(ch_q)] == 1'b0)
        else $error("finished channel still enabled");
    chk_err_sticky: assert property (errhit
        |=> error_irq && !en_q[$past(ch_q)] && state_q == S_IDLE)
        else $error("bus error not flagged");
    chk_alt_entry: assert property (state_q == S_FETCH && alt_c
        |-> bus_addr[9] && bus_addr[31:10] == table_base)
        else $error("alternate fetch outside upper table half");
    chk_pp_flip: assert property (pp_flip
        |=> alt_q[$past(ch_q)] != $past(alt_c) && chan_done != '0)
        else $error("ping-pong did not switch descriptor");

endmodule // dma_controller

// File: src/dma_pkg.sv
// shared constants, descriptor layout and state codes of the dma controller
package dma_pkg;

    // ****************************************************************
    // channel set
    // ****************************************************************
    localparam int NUM_CH = 8;
    localparam int CH_W   = 3;
    localparam int CNT_W  = 10;

    // ****************************************************************
    // descriptor control word layout
    // ****************************************************************
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_CNT_LSB  = 4;
    localparam int CTL_ARB_LSB  = 14;
    localparam int CTL_SINC_LSB = 24;
    localparam int CTL_DINC_LSB = 26;
    localparam int CTL_SIZE_LSB = 28;

    // descriptor words: source pointer, destination pointer, control
    localparam logic [1:0] W_SRC = 2'h0;
    localparam logic [1:0] W_DST = 2'h1;
    localparam logic [1:0] W_CTL = 2'h2;

    // ****************************************************************
    // encodings
    // ****************************************************************
    localparam logic [2:0] MODE_STOP   = 3'h0;
    localparam logic [2:0] MODE_BASIC  = 3'h1;
    localparam logic [2:0] MODE_AUTO   = 3'h2;
    localparam logic [2:0] MODE_PP     = 3'h3;
    localparam logic [2:0] MODE_MEM_SG = 3'h4;
    localparam logic [2:0] MODE_PER_SG = 3'h6;

    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] INC_BYTE  = 2'h0;
    localparam logic [1:0] INC_HALF  = 2'h1;
    localparam logic [1:0] INC_WORD  = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_FETCH = 3'b001,
        S_RD    = 3'b010,
        S_WR    = 3'b011,
        S_WB    = 3'b100
    } state_e;

    // address step per increment code; the fourth code holds still
    function automatic logic [31:0] inc_step(input logic [1:0] code);
        logic [31:0] s;
        s = 32'h0000_0000;
        if (code == INC_BYTE) s = 32'h0000_0001;
        if (code == INC_HALF) s = 32'h0000_0002;
        if (code == INC_WORD) s = 32'h0000_0004;
        return s;
    endfunction

endpackage

// File: src/dma_arbiter.sv
// fixed priority channel arbiter with a high and a default level
`timescale 1ns/1ps
module dma_arbiter
    import dma_pkg::*;
(
    // requests
    input  wire logic [NUM_CH-1:0] pend,
    input  wire logic [NUM_CH-1:0] high,
    // result
    output logic      [CH_W-1:0]   gnt,
    output logic                   any
);

    // high level wins when present, else the whole pending set competes
    wire [NUM_CH-1:0] hp   = pend & high;
    wire [NUM_CH-1:0] cand = (|hp) ? hp : pend;

    // scan downward so the lowest number is left standing
    always_comb begin
        gnt = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (cand[i]) gnt = CH_W'(i);
        end
    end

    assign any = |pend;

endmodule // dma_arbiter

// File: dv/dma_mem_model.sv
// system memory model answering the dma bus master
`timescale 1ns/1ps
module dma_mem_model (
    // clock
    input  wire logic        clk,
    // bus from the dma master
    input  wire logic        bus_valid,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_ready,
    output logic [31:0]      bus_rdata,
    output logic             bus_err,
    // knobs from the bench
    input  wire logic        slow,
    input  wire logic        err_en,
    input  wire logic [31:0] err_addr
);
    // ****************************************************************
    // storage and answer
    // ****************************************************************
    logic [31:0] mem [0:1023];
    logic [31:0] last_q = 32'h0000_0000;
    logic        phase_q = 1'b0;
    logic        hit;

    // slow mode answers only every other cycle, so waits get exercised
    assign hit       = bus_valid & (~slow | phase_q);
    assign bus_ready = hit;
    assign bus_err   = hit & err_en & (bus_addr == err_addr);
    // no stale data when idle: the inverse of the last read word
    assign bus_rdata = (hit & ~bus_write) ? mem[bus_addr[11:2]] : ~last_q;

    // writes land on the accepting edge; a faulted write is dropped
    always @(posedge clk) begin
        phase_q <= ~phase_q;
        if (hit & bus_write & ~bus_err)
            mem[bus_addr[11:2]] <= bus_wdata;
        if (hit & ~bus_write)
            last_q <= mem[bus_addr[11:2]];
    end
endmodule // dma_mem_model

// File: dv/tb_multichannel_dma_controller.sv
// self-checking bench for the multichannel dma controller
`timescale 1ns/1ps
module tb_multichannel_dma_controller;
    import dma_pkg::*;

    typedef struct {
        int ch; logic [2:0] mode; int cnt; int arb;
        logic [1:0] si; logic [1:0] di; logic slow;
    } row_s;

    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              ctrl_enable = 1'b1;
    logic [31:10]      table_base = 22'h00_0000; // aligned
    logic [NUM_CH-1:0] prio_high = '0;
    logic [NUM_CH-1:0] chan_enable_set = '0;
    logic [NUM_CH-1:0] chan_disable = '0;
    logic [NUM_CH-1:0] sw_req = '0;
    logic [NUM_CH-2:0] periph_req = '0;
    logic              err_clear = 1'b0;
    logic              cpu_bus_busy = 1'b0;
    logic              slow = 1'b0;
    logic              err_en = 1'b0;
    logic [NUM_CH-1:0] chan_enabled, chan_done;
    logic              error_irq, bus_valid, bus_write, bus_ready, bus_err;
    logic [31:0]       bus_addr, bus_wdata, bus_rdata, first_rd;
    logic [1:0]        bus_size;
    logic              rd_seen = 1'b0;
    logic              alt_hit = 1'b0;
    int                done_cnt [NUM_CH] = '{default: 0};
    int                busy_viol = 0;
    int                failures = 0;
    int                cmp_count = 0;
    row_s rows [5] = '{
        '{0, MODE_AUTO,  4, 1, INC_WORD, INC_WORD, 1'b0},
        '{3, MODE_BASIC, 3, 0, INC_WORD, INC_WORD, 1'b1},
        '{7, MODE_AUTO,  5, 2, 2'h3,     INC_WORD, 1'b0},
        '{1, MODE_AUTO,  2, 3, INC_WORD, 2'h3,     1'b1},
        '{6, MODE_BASIC, 4, 2, INC_WORD, INC_WORD, 1'b0}};

    // ****************************************************************
    // design, memory and clock
    // ****************************************************************
    dma_controller i_dma_controller (.clk(clk), .reset(reset),
        .ctrl_enable(ctrl_enable), .table_base(table_base),
        .prio_high(prio_high), .chan_enable_set(chan_enable_set),
        .chan_disable(chan_disable), .sw_req(sw_req),
        .periph_req(periph_req), .err_clear(err_clear),
        .chan_enabled(chan_enabled), .chan_done(chan_done),
        .error_irq(error_irq), .cpu_bus_busy(cpu_bus_busy),
        .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_ready(bus_ready),
        .bus_rdata(bus_rdata), .bus_err(bus_err));
    dma_mem_model i_dma_mem_model (.clk(clk), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_err(bus_err),
        .slow(slow), .err_en(err_en), .err_addr(32'h0000_0800));

    initial begin
        forever #10 clk = ~clk;
    end

    // bus monitor: done pulses, first read, alternate fetch, busy overlap
    always @(posedge clk) begin
        if (bus_valid && cpu_bus_busy) busy_viol++;
        for (int i = 0; i < NUM_CH; i++)
            if (chan_done[i] === 1'b1) done_cnt[i]++;
        if (bus_valid && bus_ready && !bus_write) begin
            if (!rd_seen) first_rd = bus_addr;
            rd_seen = 1'b1;
            if (bus_addr == 32'h0000_0240) alt_hit = 1'b1;
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {8'h5a, a[23:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // descriptor at table entry idx, source 0x800, destination 0xc00
    task automatic prep(input int idx, input logic [2:0] mode,
                        input int cnt, arb, input logic [1:0] si, di);
        for (int k = 0; k < 64; k++) begin
            i_dma_mem_model.mem[512+k] = pat(32'h0000_0800 + 4*k);
            i_dma_mem_model.mem[768+k] = 32'h0000_0000;
        end
        i_dma_mem_model.mem[idx*4]   = 32'h0000_0800;
        i_dma_mem_model.mem[idx*4+1] = 32'h0000_0c00;
        i_dma_mem_model.mem[idx*4+2] = {2'h0, SIZE_WORD, di, si, 6'h00,
                                        arb[3:0], cnt[9:0], 1'b0, mode};
    endtask

    task automatic wait_done(input int ch, input int target);
        int k;
        k = 0;
        while (done_cnt[ch] < target && k < 3000) begin
            step(1);
            k++;
        end
        check("done pulses", target, done_cnt[ch]);
    endtask

    task automatic check_data(input int cnt, input logic [1:0] si, di);
        int ss, ds;
        ss = (si == INC_WORD) ? 4 : 0;
        ds = (di == INC_WORD) ? 4 : 0;
        // a held destination keeps only the last item
        for (int i = 0; i < cnt; i++)
            if (ds != 0 || i == cnt - 1)
                check("item", pat(32'h0000_0800 + i*ss),
                      i_dma_mem_model.mem[768 + i*ds/4]);
    endtask

    task automatic kick(input int ch, input logic hold);
        chan_enable_set[ch] = 1'b1;
        step(1);
        chan_enable_set = '0;
        sw_req[ch] = 1'b1;
        step(1);
        if (!hold) sw_req = '0;
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        print_verdict;
    end

    initial begin
        step(8);
        check("enabled in reset", 8'h00, chan_enabled);
        check("valid in reset", 1'b0, bus_valid);
        reset = 1'b0;
        step(2);
        // table rows: auto and basic, held or stepped pointers, bursts
        foreach (rows[r]) begin
            slow = rows[r].slow;
            prep(rows[r].ch, rows[r].mode, rows[r].cnt, rows[r].arb,
                 rows[r].si, rows[r].di);
            kick(rows[r].ch, rows[r].mode == MODE_BASIC);
            wait_done(rows[r].ch, 1);
            sw_req = '0;
            step(2);
            check_data(rows[r].cnt, rows[r].si, rows[r].di);
            check("left", 10'h000, i_dma_mem_model.mem[rows[r].ch*4+2][13:4]);
            check("enabled", 1'b0, chan_enabled[rows[r].ch]);
            $display("row %0d done", r);
        end
        slow = 1'b0;
        // basic mode pauses once a single request pulse is used up
        prep(2, MODE_BASIC, 4, 0, INC_WORD, INC_WORD);
        kick(2, 1'b0);
        step(60);
        check("paused done", 0, done_cnt[2]);
        check("paused enabled", 1'b1, chan_enabled[2]);
        check("paused left", 10'h003, i_dma_mem_model.mem[10][13:4]);
        periph_req[2] = 1'b1;
        wait_done(2, 1);
        periph_req = '0;
        check_data(4, INC_WORD, INC_WORD);
        $display("basic pause done");
        // high level wins, and nothing moves while the processor holds the bus
        cpu_bus_busy = 1'b1;
        prio_high = 8'h20;
        prep(1, MODE_AUTO, 1, 0, INC_WORD, INC_WORD);
        prep(5, MODE_AUTO, 1, 0, INC_WORD, INC_WORD);
        rd_seen = 1'b0;
        chan_enable_set = 8'h22;
        step(1);
        chan_enable_set = '0;
        sw_req = 8'h22;
        step(1);
        sw_req = '0;
        step(20);
        check("read while busy", 1'b0, rd_seen);
        cpu_bus_busy = 1'b0;
        wait_done(5, done_cnt[5] + 1);
        wait_done(1, done_cnt[1] + 1);
        check("first fetch", 32'h0000_0050, first_rd);
        check("busy overlap", 0, busy_viol);
        // same level: the lower channel number goes first
        prio_high = '0;
        prep(6, MODE_AUTO, 1, 0, INC_WORD, INC_WORD);
        prep(2, MODE_AUTO, 1, 0, INC_WORD, INC_WORD);
        rd_seen = 1'b0;
        chan_enable_set = 8'h44;
        step(1);
        chan_enable_set = '0;
        sw_req = 8'h44;
        step(1);
        sw_req = '0;
        wait_done(2, done_cnt[2] + 1);
        wait_done(6, done_cnt[6] + 1);
        check("first fetch", 32'h0000_0020, first_rd);
        $display("priority done");
        // ping-pong flips to the alternate entry, which stops it
        prep(36, MODE_STOP, 0, 0, INC_WORD, INC_WORD);
        prep(4, MODE_PP, 2, 1, INC_WORD, INC_WORD);
        alt_hit = 1'b0;
        kick(4, 1'b1);
        wait_done(4, 2);
        sw_req = '0;
        step(2);
        check("alternate read", 1'b1, alt_hit);
        check("pp enabled", 1'b0, chan_enabled[4]);
        check_data(2, INC_WORD, INC_WORD);
        $display("ping-pong done");
        // one auto task at 0x400; the alternate starts empty, so it must be copied
        prep(39, MODE_AUTO, 2, 1, INC_WORD, INC_WORD);
        for (int k = 0; k < 4; k++) begin
            i_dma_mem_model.mem[256+k] = i_dma_mem_model.mem[156+k];
            i_dma_mem_model.mem[156+k] = 32'h0000_0000;
        end
        prep(7, MODE_MEM_SG, 4, 2, INC_WORD, INC_WORD);
        i_dma_mem_model.mem[28] = 32'h0000_0400;
        kick(7, 1'b0);
        wait_done(7, 2);
        check_data(2, INC_WORD, INC_WORD);
        check("sg enabled", 1'b0, chan_enabled[7]);
        $display("scatter-gather done");
        // a faulted source read disables the channel and flags an error
        err_en = 1'b1;
        prep(0, MODE_AUTO, 2, 1, INC_WORD, INC_WORD);
        kick(0, 1'b0);
        for (int k = 0; k < 200 && error_irq !== 1'b1; k++) step(1);
        check("error flag", 1'b1, error_irq);
        check("error enabled", 1'b0, chan_enabled[0]);
        step(5);
        check("error done", 1, done_cnt[0]);
        err_en = 1'b0;
        check("error sticky", 1'b1, error_irq);
        err_clear = 1'b1;
        step(1);
        err_clear = 1'b0;
        step(1);
        check("error cleared", 1'b0, error_irq);
        $display("bus error done");
        // a second reset drops every enable
        chan_enable_set = 8'h08;
        step(1);
        chan_enable_set = '0;
        check("enable set", 1'b1, chan_enabled[3]);
        reset = 1'b1;
        step(1);
        check("enabled after reset", 8'h00, chan_enabled);
        reset = 1'b0;
        step(2);
        $display("reset done");
        print_verdict;
    end
endmodule // tb_multichannel_dma_controller
